/* gpib_byte_fifo.sv */
module gpib_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wr_q] <= in_data;
        wr_q      <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* gpib_dma_completion_status.sv */
`include "gpib_dma_defs.svh"
module gpib_dma_completion_status #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic                          clk,
  input  wire logic                          srst,
  input  wire logic                          ce,
  input  wire logic                          ch0_start,
  input  wire logic                          ch1_start,
  input  wire logic                          ch0_abort,
  input  wire logic                          ch1_abort,
  input  wire logic                          ch0_misconfig,
  input  wire logic                          ch1_misconfig,
  input  wire logic                          ch0_stat_clear,
  input  wire logic                          ch1_stat_clear,
  input  wire logic                          ch0_last_byte,
  input  wire logic                          carry_mode,
  input  wire logic                          channel_irq_enable,
  input  wire logic                          bus_error,
  input  wire logic                          config_write_one,
  input  wire logic                          listeners_accepted,
  input  wire logic                          ctrl_req,
  output logic                               dma_req,
  input  wire logic                          dma_ack,
  input  wire logic [15:0]                   memory_transfer_count,
  input  wire logic                          addressed_talk,
  input  wire logic                          addressed_listen,
  input  wire logic                          status_one_read,
  input  wire logic                          status_two_read,
  input  wire logic                          end_irq_enable,
  input  wire logic                          eos_ends_receive,
  input  wire logic                          eight_bit_eos_compare,
  input  wire logic [7:0]                    eos_char_reg,
  input  wire logic                          bus_byte_valid,
  input  wire logic [7:0]                    bus_byte,
  input  wire logic                          bus_end,
  output logic                               bus_byte_ready,
  input  wire logic                          rx_byte_read,
  output logic [7:0]                         rx_byte,
  output logic                               rx_byte_valid,
  input  wire logic                          tx_byte_write,
  output gpib_dma_pkg::chan_stat_type        ch0_status,
  output gpib_dma_pkg::chan_stat_type        ch1_status,
  output gpib_dma_pkg::status_one_type       gpib_status_one,
  output logic                               status_two_int,
  output logic                               irq_req,
  output logic                               peripheral_control_line
);
  import gpib_dma_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Channel state; status ports always live, reads never stall
  chan_state_type st0_q, st1_q;
  chan_stat_type  c0_q, c1_q;
  logic           sync_q, tlc_int_q, line_q;
  logic           ch0_active, ch1_active;
  status_one_type s1_q;

  assign ch0_active = (st0_q == CH_RUN);
  assign ch1_active = (st1_q != CH_IDLE);

  // Carry gate: count of one after last byte blocks further requests
  wire carry_block = carry_mode && ch0_last_byte && ch1_active &&
                     (memory_transfer_count == `CARRY_HOLD);
  assign dma_req   = ctrl_req && !carry_block;

  // Completion: all blocks moved and listeners synchronized
  wire done_all = ch0_last_byte && listeners_accepted &&
                  (st0_q != CH_IDLE);

  // Line is low while any source holds it; OR of three sources
  wire line_low  = tlc_int_q || sync_q || bus_error;
  wire line_fall = line_q && line_low;
  assign peripheral_control_line = !line_low;

  //////////////////////////////////////////////////////////////////////////
  function automatic chan_stat_type upd(input chan_stat_type s,
                                        input logic clr,
                                        input logic fault,
                                        input logic [7:0] code);
    chan_stat_type r;
    r = s;
    if (clr) begin
      r.fault      = 1'b0;
      r.finished   = 1'b0;
      r.edge_flag  = 1'b0;
      r.error_code = `CER_NONE;
    end
    if (fault) begin
      r.fault      = 1'b1;
      r.error_code = code;
    end
    return r;
  endfunction

  wire [7:0] c0_code = ch0_misconfig ? `CER_CONFIG :
                       (bus_error && ch0_active) ? `CER_BUSERR : `CER_NONE;
  wire [7:0] c1_code = ch1_misconfig ? `CER_CONFIG :
                       (bus_error && st1_q == CH_RUN) ? `CER_BUSERR :
                       `CER_NONE;
  wire f0 = ch0_misconfig || ch0_abort ||
            (bus_error && ch0_active);
  wire f1 = ch1_misconfig || ch1_abort ||
            (bus_error && st1_q == CH_RUN && !ch0_active);

  always_ff @(posedge clk) begin
    if (srst) begin
      st0_q  <= CH_IDLE;
      st1_q  <= CH_IDLE;
      c0_q   <= '0;
      c1_q   <= '0;
      sync_q <= 1'b0;
      line_q <= 1'b1;
    end else if (ce) begin
      line_q <= !line_low;
      // Config write releases sync; a same-cycle sync still wins
      if (done_all && !sync_q)
        sync_q <= 1'b1;
      else if (config_write_one)
        sync_q <= 1'b0;
      // Channel 0 ends on fault or on completion
      if (f0)
        st0_q <= CH_IDLE;
      else if (ch0_start)
        st0_q <= CH_RUN;
      else if (done_all)
        st0_q <= CH_IDLE;
      // Channel 1 holds in carry mode until aborted, misconfigured or restarted
      if (f1)
        st1_q <= CH_IDLE;
      else if (ch1_start)
        st1_q <= CH_RUN;
      else if (carry_block)
        st1_q <= CH_HOLD;
      c0_q <= upd(c0_q, ch0_stat_clear, f0, ch0_abort ? `CER_NONE : c0_code);
      if (done_all && st0_q == CH_RUN && !f0)
        c0_q.finished <= 1'b1;
      c1_q <= upd(c1_q, ch1_stat_clear, f1, ch1_abort ? `CER_NONE : c1_code);
      if (line_fall)
        c1_q.edge_flag <= 1'b1;
      // Channel 1 never finishes in carry mode; finished stays clear
      if (!carry_mode && done_all && ch1_active && !f1)
        c1_q.finished <= 1'b1;
    end
  end

  always_comb begin
    ch0_status            = c0_q;
    ch1_status            = c1_q;
    ch0_status.line_level = 1'b1;
    ch1_status.line_level = line_q;
  end

  // No interrupt from a misconfig fault; only edge or finish
  assign irq_req = channel_irq_enable &&
                   (c1_q.edge_flag || c1_q.finished);

  //////////////////////////////////////////////////////////////////////////
  // Receive path buffered so bursts from the bus are not lost
  logic [7:0] f_data;
  logic       f_valid;
  logic       f_end;
  logic       rx_valid_q;
  logic [7:0] rx_q;
  wire        f_ready = addressed_listen && (!rx_valid_q || rx_byte_read);

  gpib_byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .in_data   ({bus_end, bus_byte}),
    .in_valid  (bus_byte_valid),
    .in_ready  (bus_byte_ready),
    .out_data  ({f_end, f_data}),
    .out_valid (f_valid),
    .out_ready (f_ready)
  );

  wire take = f_valid && f_ready;
  // Seven-bit compare unless eight-bit compare selected
  wire eos_hit = eight_bit_eos_compare ? (f_data == eos_char_reg) :
                 (f_data[6:0] == eos_char_reg[6:0]);
  wire end_set = take && (f_end || (eos_ends_receive && eos_hit));
  logic tx_full_q, tx_empty_seen_q;

  assign rx_byte       = rx_q;
  assign rx_byte_valid = rx_valid_q;
  assign gpib_status_one = s1_q;
  assign status_two_int  = tlc_int_q;

  // Controller interrupt: end-received with its enable only
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q            <= '0;
      rx_q            <= '0;
      rx_valid_q      <= 1'b0;
      tx_full_q       <= 1'b0;
      tx_empty_seen_q <= 1'b0;
      tlc_int_q       <= 1'b0;
    end else if (ce) begin
      if (take) begin
        rx_q       <= f_data;
        rx_valid_q <= 1'b1;
      end else if (rx_byte_read)
        rx_valid_q <= 1'b0;
      if (tx_byte_write)
        tx_full_q <= 1'b1;
      else if (listeners_accepted)
        tx_full_q <= 1'b0;
      tx_empty_seen_q <= addressed_talk && !tx_full_q;
      // Read clears, but a set in the same cycle wins
      s1_q.do_flag <= (s1_q.do_flag && !status_one_read) ||
        (addressed_talk && !tx_full_q && !tx_empty_seen_q) ||
        (addressed_talk && tx_full_q && listeners_accepted);
      s1_q.di_flag <= (s1_q.di_flag && !status_one_read) ||
                      (take && addressed_listen);
      s1_q.end_rx  <= (s1_q.end_rx && !status_one_read) || end_set;
      // Status-one read clears the summary too
      tlc_int_q <= (end_set && end_irq_enable) ||
                   (tlc_int_q && !status_one_read && !status_two_read);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  edge_flag_a: assert property (@(posedge clk) disable iff (srst)
    ce && line_q && line_low |=> c1_q.edge_flag)
    else $error("line fall did not set edge flag");
  misc_fault_a: assert property (@(posedge clk) disable iff (srst)
    ce && ch0_misconfig |=> c0_q.fault && c0_q.error_code == `CER_CONFIG
    && st0_q == CH_IDLE)
    else $error("misconfig not faulted");
  bus_err_a: assert property (@(posedge clk) disable iff (srst)
    ce && bus_error && ch0_active && !ch1_misconfig && !ch1_abort
    |=> c0_q.fault && !c1_q.fault)
    else $error("bus error flags wrong");
  carry_gate_a: assert property (@(posedge clk) disable iff (srst)
    carry_block |-> !dma_req)
    else $error("request passed carry gate");
  cfg_release_a: assert property (@(posedge clk) disable iff (srst)
    ce && config_write_one && !done_all
    |=> !sync_q)
    else $error("line not released");
  irq_path_a: assert property (@(posedge clk) disable iff (srst)
    c1_q.edge_flag && channel_irq_enable |-> irq_req)
    else $error("edge flag gave no irq");
  end_rx_a: assert property (@(posedge clk) disable iff (srst)
    ce && end_set |=> s1_q.end_rx)
    else $error("end flag missed");
  rd_clear_a: assert property (@(posedge clk) disable iff (srst)
    ce && status_one_read && !take && !addressed_talk
    |=> !s1_q.di_flag && !s1_q.end_rx)
    else $error("status one not cleared");
endmodule

/* gpib_dma_defs.svh */
`ifndef GPIB_DMA_DEFS_SVH
`define GPIB_DMA_DEFS_SVH
// Contract
// - Registers stay accessible during DMA operation
// - Misprogrammed channel ends, faults, config code, no irq
// - Done and synchronized drives channel one line edge
// - Edge flag requests interrupt when enabled, else polled
// - Three events share the channel one line
// - Channel zero bus error sets edge, zero fault
// - Carry mode blocks requests when count is one; code also needs last byte and channel one active
// - Last carry entry asks two bytes, no finish
// - Success leaves channel zero finished, no fault
// - Config write clears sync and releases line
// - Read status two before status one
// - End flag on END or enabled EOS match
// - End flag with both enables raises interrupt
// - Software abort sets fault; host clears it
// - Output ready on talker empty, again after accept
// - Input ready on listener byte, again next byte
// - Reading status one clears its bits
// - Line events only on high-to-low edges
// - Three line sources combined by OR
// - Bus error line releases when error ends
`define CER_NONE    8'h00
`define CER_CONFIG  8'h01
`define CER_BUSERR  8'h09
`define CARRY_HOLD  16'h0001
`define FIFO_DEPTH  16
`define BYTE_W      8
`endif

/* gpib_dma_pkg.sv */
package gpib_dma_pkg;
  typedef struct packed {
    logic       finished;
    logic       fault;
    logic       edge_flag;
    logic       line_level;
    logic [7:0] error_code;
  } chan_stat_type;
  typedef struct packed {
    logic do_flag;
    logic di_flag;
    logic end_rx;
  } status_one_type;
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_RUN  = 2'b01,
    CH_HOLD = 2'b10
  } chan_state_type;
endpackage

/* gpib_talker_model.sv */
module gpib_talker_model (
  input  wire logic       clk,
  input  wire logic       bus_byte_ready,
  output logic            bus_byte_valid,
  output logic [7:0]      bus_byte,
  output logic            bus_end
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    bus_byte_valid = 1'b0;
    bus_byte = 8'h00;
    bus_end = 1'b0;
  end
  // Byte and END held until the rising edge that takes them
  task automatic send(input logic [7:0] b, input logic e);
    @(negedge clk);
    bus_byte_valid = 1'b1;
    bus_byte = b;
    bus_end = e;
    do @(posedge clk); while (bus_byte_ready !== 1'b1);
    @(negedge clk);
    bus_byte_valid = 1'b0;
    // Released lines never show the stale byte
    bus_byte = ~b;
    bus_end = ~e;
  endtask
endmodule

/* testbench.sv */
module testbench
  import gpib_dma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = 16;
  logic clk, srst, ce, dma_ack, ch0_start, ch1_start, ch0_abort, ch1_abort;
  logic ch0_misconfig, ch1_misconfig, ch0_stat_clear, ch1_stat_clear;
  logic ch0_last_byte, carry_mode, channel_irq_enable, bus_error, ctrl_req;
  logic config_write_one, listeners_accepted, dma_req, addressed_talk;
  logic addressed_listen, status_one_read, status_two_read, bus_end;
  logic end_irq_enable, eos_ends_receive, eight_bit_eos_compare;
  logic bus_byte_valid, bus_byte_ready, rx_byte_read, rx_byte_valid;
  logic tx_byte_write, status_two_int, irq_req, peripheral_control_line;
  logic [15:0] memory_transfer_count;
  logic [7:0] eos_char_reg, bus_byte, rx_byte;
  chan_stat_type ch0_status, ch1_status;
  status_one_type gpib_status_one;
  int failures, check_count;
  typedef struct {logic r, b, ie, en; logic [7:0] eos, by; logic ex;} row_type;
  row_type rows[6] = '{'{0, 0, 0, 0, 8'h0A, 8'h0A, 0},
    '{1, 0, 1, 0, 8'h0A, 8'h0A, 1}, '{1, 0, 0, 0, 8'h0A, 8'h8A, 1},
    '{1, 1, 0, 0, 8'h0A, 8'h8A, 0}, '{1, 1, 0, 0, 8'h8A, 8'h8A, 1},
    '{0, 1, 1, 1, 8'h55, 8'h12, 1}};
  gpib_dma_completion_status #(.FIFO_DEPTH(DEPTH)) u_dut (
    .clk, .srst, .ce, .ch0_start, .ch1_start, .ch0_abort, .ch1_abort,
    .ch0_misconfig, .ch1_misconfig, .ch0_stat_clear, .ch1_stat_clear,
    .ch0_last_byte, .carry_mode, .channel_irq_enable, .bus_error,
    .config_write_one, .listeners_accepted, .ctrl_req, .dma_req, .dma_ack,
    .memory_transfer_count, .addressed_talk, .addressed_listen,
    .status_one_read, .status_two_read, .end_irq_enable, .eos_ends_receive,
    .eight_bit_eos_compare, .eos_char_reg, .bus_byte_valid, .bus_byte,
    .bus_end, .bus_byte_ready, .rx_byte_read, .rx_byte, .rx_byte_valid,
    .tx_byte_write, .ch0_status, .ch1_status, .gpib_status_one,
    .status_two_int, .irq_req, .peripheral_control_line);
  gpib_talker_model u_talk (.clk, .bus_byte_ready, .bus_byte_valid,
    .bus_byte, .bus_end);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  // Bounded wait for the slot, then consume it
  task automatic take(input logic [7:0] e);
    int k;
    k = 0;
    while (rx_byte_valid !== 1'b1 && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk("rx_byte", 16'(e), 16'(rx_byte));
    chk("di_flag", 1, gpib_status_one.di_flag);
    pulse(rx_byte_read);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop;
  end
  initial begin
    {ce, srst, dma_ack} = 3'b110;
    {ch0_start, ch1_start, ch0_abort, ch1_abort, ch0_misconfig,
     ch1_misconfig, ch0_stat_clear, ch1_stat_clear, ch0_last_byte,
     carry_mode, channel_irq_enable, bus_error, config_write_one,
     listeners_accepted, ctrl_req, addressed_talk, addressed_listen,
     status_one_read, status_two_read, end_irq_enable, eos_ends_receive,
     eight_bit_eos_compare, rx_byte_read, tx_byte_write} = '0;
    memory_transfer_count = 16'h0000;
    eos_char_reg = 8'h00;
    repeat (16) @(negedge clk);
    srst = 1'b0;
    chk("ch1_status", 16'h0100, 16'(ch1_status));
    chk("pcl", 1, peripheral_control_line);
    addressed_listen = 1'b1;
    channel_irq_enable = 1'b1;
    foreach (rows[i]) begin
      eos_ends_receive = rows[i].r;
      eight_bit_eos_compare = rows[i].b;
      end_irq_enable = rows[i].ie;
      eos_char_reg = rows[i].eos;
      u_talk.send(rows[i].by, rows[i].en);
      take(rows[i].by);
      repeat (4) @(negedge clk);
      chk("end_rx", 16'(rows[i].ex), 16'(gpib_status_one.end_rx));
      chk("irq_req", 16'(rows[i].ex & rows[i].ie), 16'(irq_req));
      chk("int2", 16'(rows[i].ex & rows[i].ie), 16'(status_two_int));
      pulse(status_two_read);
      chk("int2 clr", 0, 16'(status_two_int));
      pulse(status_one_read);
      chk("end_rx clr", 0, 16'(gpib_status_one.end_rx));
      pulse(ch1_stat_clear);
    end
    // Fill with the listener off so nothing drains
    addressed_listen = 1'b0;
    for (int i = 0; i < DEPTH; i++) u_talk.send(8'(i * 17), 1'b0);
    @(negedge clk);
    chk("full ready", 0, 16'(bus_byte_ready));
    addressed_listen = 1'b1;
    for (int i = 0; i < DEPTH; i++) begin
      take(8'(i * 17));
      @(negedge clk);
    end
    chk("empty ready", 1, 16'(bus_byte_ready));
    pulse(ch0_misconfig);
    chk("ch0 misconfig", 16'h0501, 16'(ch0_status));
    chk("irq misconfig", 0, 16'(irq_req));
    pulse(ch0_stat_clear);
    pulse(ch0_start);
    bus_error = 1'b1;
    repeat (3) @(negedge clk);
    chk("pcl berr", 0, 16'(peripheral_control_line));
    chk("ch0 berr", 16'h0109, {ch0_status.fault, ch0_status.error_code});
    chk("ch1 berr", 1, {ch1_status.fault, ch1_status.edge_flag});
    bus_error = 1'b0;
    @(negedge clk);
    chk("pcl release", 1, 16'(peripheral_control_line));
    pulse(ch1_stat_clear);
    pulse(ch0_abort);
    chk("ch0 abort", 16'h0100, {ch0_status.fault, ch0_status.error_code});
    pulse(ch0_stat_clear);
    chk("ch0 fault clr", 0, 16'(ch0_status.fault));
    // Carry transfer, polled first, then interrupt enabled
    carry_mode = 1'b1;
    memory_transfer_count = 16'h0001;
    channel_irq_enable = 1'b0;
    ctrl_req = 1'b1;
    pulse(ch1_start);
    pulse(ch0_start);
    chk("dma_req pass", 1, 16'(dma_req));
    ch0_last_byte = 1'b1;
    @(negedge clk);
    chk("dma_req hold", 0, 16'(dma_req));
    listeners_accepted = 1'b1;
    repeat (4) @(negedge clk);
    chk("ch0 done", 2, {ch0_status.finished, ch0_status.fault});
    chk("ch1 done", 1, {ch1_status.finished, ch1_status.edge_flag});
    chk("irq polled", 0, 16'(irq_req));
    channel_irq_enable = 1'b1;
    @(negedge clk);
    chk("irq sync", 1, 16'(irq_req));
    {ch0_last_byte, listeners_accepted, ctrl_req} = 3'b000;
    pulse(config_write_one);
    chk("pcl cfg", 1, 16'(peripheral_control_line));
    pulse(ch1_abort);
    chk("ch1 abort", 1, 16'(ch1_status.fault));
    pulse(ch1_stat_clear);
    addressed_talk = 1'b1;
    repeat (3) @(negedge clk);
    chk("do_flag", 1, 16'(gpib_status_one.do_flag));
    pulse(tx_byte_write);
    pulse(status_one_read);
    chk("do busy", 0, 16'(gpib_status_one.do_flag));
    pulse(listeners_accepted);
    chk("do again", 1, 16'(gpib_status_one.do_flag));
    addressed_talk = 1'b0;
    pulse(status_one_read);
    chk("do clr", 0, 16'(gpib_status_one.do_flag));
    report_and_stop;
  end
endmodule
